// ### rtl/mie_pkg.sv
// Constants, types and decode codes for the move-instruction execute block.
// Assumes one core clock; instruction words arrive right-justified in 16 bits.
package mie_pkg;
  localparam int DATA_W = 4;
  localparam int ADDR_W = 7;
  localparam int MEM_DEPTH = 128;
  localparam int INSTR_W = 16;
  localparam int WSEL_W = 4;
  // Field positions inside the instruction word
  localparam int ADDR_LSB = 0;
  localparam int WSEL_LSB = 7;
  localparam int LONG_OP_LSB = 7;
  localparam int SHORT_OP_LSB = 11;
  localparam int PAGE_BITS = 3;
  // Opcode prefixes, nine bits at [15:7]
  localparam logic [8:0] OP_PRELOAD_LO = 9'h02a;
  localparam logic [8:0] OP_PRELOAD_HI = 9'h02b;
  localparam logic [8:0] OP_PAGE_LD = 9'h05d;
  localparam logic [8:0] OP_CARRY_MV = 9'h0b2;
  localparam logic [8:0] OP_HOLD_HI = 9'h093;
  localparam logic [8:0] OP_HOLD_LO = 9'h092;
  // Opcode prefixes, five bits at [15:11]
  localparam logic [4:0] OP_WR_LD = 5'h0d;
  localparam logic [4:0] OP_WR_IND_LD = 5'h19;
  localparam logic [4:0] OP_WR_IND_ST = 5'h1b;
  // Bit 3 of the lower release nibble is reserved and reads as zero
  localparam logic [3:0] HOLD_LO_MASK = 4'h7;
  localparam logic [3:0] NIB_RST = 4'h0;
  localparam logic [3:0] PAGE_RST = 4'h0;
  localparam logic ZERO_RST = 1'b0;

  typedef enum logic [3:0] {
    MIE_OP_NONE,
    MIE_OP_PRELOAD_LO,
    MIE_OP_PRELOAD_HI,
    MIE_OP_WR_LD,
    MIE_OP_WR_IND_LD,
    MIE_OP_WR_IND_ST,
    MIE_OP_PAGE_LD,
    MIE_OP_CARRY_MV,
    MIE_OP_HOLD_HI,
    MIE_OP_HOLD_LO
  } mie_op_e;

  typedef enum logic {
    MIE_IDLE,
    MIE_INDIRECT
  } mie_state_e;

  typedef struct packed {
    logic valid;
    logic [INSTR_W-1:0] word;
  } mie_instr_s;

  typedef struct packed {
    logic [DATA_W-1:0] accumulator;
    logic zero_flag;
  } mie_acc_s;
endpackage

// ### rtl/mie_core.sv
// Execute logic for the data-move instruction group of a 4-bit core.
// Assumes the sequencer offers one instruction at a time and holds it while
// instr_ready is low; carry and hold-release cause flags come from outside.
module mie_core
  import mie_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Instruction offer
  input mie_pkg::mie_instr_s instr,
  output logic instr_ready,
  output logic instr_done,
  // Flags owned by other parts of the core
  input wire logic carry_flag,
  input wire logic [7:0] hold_release_cause_flags,
  // Results
  output mie_pkg::mie_acc_s acc_out,
  output logic [mie_pkg::DATA_W-1:0] timer_b_preload_low,
  output logic [mie_pkg::DATA_W-1:0] timer_b_preload_high,
  output logic [mie_pkg::DATA_W-1:0] memory_page_reg,
  // Data memory observation
  input wire logic [mie_pkg::ADDR_W-1:0] peek_addr,
  output logic [mie_pkg::DATA_W-1:0] peek_data
);
  import mie_pkg::*;

  function automatic mie_op_e mie_decode(input logic [INSTR_W-1:0] w);
    logic [8:0] lop;
    logic [4:0] sop;
    lop = w[LONG_OP_LSB +: 9];
    sop = w[SHORT_OP_LSB +: 5];
    mie_decode = MIE_OP_NONE;
    if (lop == OP_PRELOAD_LO) begin
      mie_decode = MIE_OP_PRELOAD_LO;
    end else if (lop == OP_PRELOAD_HI) begin
      mie_decode = MIE_OP_PRELOAD_HI;
    end else if (lop == OP_PAGE_LD) begin
      mie_decode = MIE_OP_PAGE_LD;
    end else if (lop == OP_CARRY_MV) begin
      mie_decode = MIE_OP_CARRY_MV;
    end else if (lop == OP_HOLD_HI) begin
      mie_decode = MIE_OP_HOLD_HI;
    end else if (lop == OP_HOLD_LO) begin
      mie_decode = MIE_OP_HOLD_LO;
    end else if (sop == OP_WR_LD) begin
      mie_decode = MIE_OP_WR_LD;
    end else if (sop == OP_WR_IND_LD) begin
      mie_decode = MIE_OP_WR_IND_LD;
    end else if (sop == OP_WR_IND_ST) begin
      mie_decode = MIE_OP_WR_IND_ST;
    end
  endfunction

  // Working register n is data memory nibble n, so widen the select
  function automatic logic [ADDR_W-1:0] mie_wr_addr(input logic [WSEL_W-1:0] s);
    mie_wr_addr = {{(ADDR_W-WSEL_W){1'b0}}, s};
  endfunction

  // Storage and state
  logic [DATA_W-1:0] mem [MEM_DEPTH];
  logic [DATA_W-1:0] next_mem [MEM_DEPTH];
  mie_state_e state;
  mie_state_e next_state;
  logic ind_store;
  logic next_ind_store;
  logic [WSEL_W-1:0] ind_wsel;
  logic [WSEL_W-1:0] next_ind_wsel;
  logic [DATA_W-1:0] ind_off;
  logic [DATA_W-1:0] next_ind_off;
  mie_acc_s next_acc_out;
  logic [DATA_W-1:0] next_preload_low;
  logic [DATA_W-1:0] next_preload_high;
  logic [DATA_W-1:0] next_page;
  logic next_instr_ready;
  logic next_instr_done;
  logic [DATA_W-1:0] next_peek_data;

  // Decode helpers
  mie_op_e op;
  logic take;
  logic [ADDR_W-1:0] r_addr;
  logic [ADDR_W-1:0] w_addr;
  logic [ADDR_W-1:0] ind_w_addr;
  logic [ADDR_W-1:0] paged_addr;
  logic [DATA_W-1:0] r_data;
  logic [DATA_W-1:0] mova_val;
  logic mova;

  // Decode, shared by every group of state below except the peek register
  always_comb begin
    // Offers are only looked at while idle
    take = instr.valid && (state == MIE_IDLE);
    op = mie_decode(instr.word);
    r_addr = instr.word[ADDR_LSB +: ADDR_W];
    w_addr = mie_wr_addr(instr.word[WSEL_LSB +: WSEL_W]);
    ind_w_addr = mie_wr_addr(ind_wsel);
    r_data = mem[r_addr];
    // Page bits 2..0 pick a 16-nibble page, the fetched nibble the offset
    paged_addr = {memory_page_reg[PAGE_BITS-1:0], ind_off};
  end

  // Flag-reading moves: one value feeds accumulator and memory alike
  always_comb begin
    mova = 1'b0;
    mova_val = NIB_RST;
    if (take) begin
      case (op)
        MIE_OP_CARRY_MV: begin
          mova = 1'b1;
          mova_val = {3'h0, carry_flag};
        end
        MIE_OP_HOLD_HI: begin
          mova = 1'b1;
          mova_val = hold_release_cause_flags[7:4];
        end
        MIE_OP_HOLD_LO: begin
          mova = 1'b1;
          // Reserved bit 3 reads as zero whatever the hold logic leaves there
          mova_val = hold_release_cause_flags[3:0] & HOLD_LO_MASK;
        end
        default: begin
          mova = 1'b0;
        end
      endcase
    end
  end

  // Sequencer: an indirect move holds ready low for its second cycle
  always_comb begin
    next_state = state;
    next_ind_store = ind_store;
    next_ind_wsel = ind_wsel;
    next_ind_off = ind_off;
    next_instr_ready = 1'b1;
    next_instr_done = 1'b0;
    case (state)
      MIE_IDLE: begin
        if (take) begin
          case (op)
            MIE_OP_WR_IND_LD, MIE_OP_WR_IND_ST: begin
              // First cycle only fetches the offset
              next_ind_store = (op == MIE_OP_WR_IND_ST);
              next_ind_wsel = instr.word[WSEL_LSB +: WSEL_W];
              next_ind_off = r_data;
              next_state = MIE_INDIRECT;
              next_instr_ready = 1'b0;
            end
            MIE_OP_NONE: begin
              // Foreign opcodes belong to other units: no done pulse
              next_instr_done = 1'b0;
            end
            default: begin
              // Every other move of the group finishes in one cycle
              next_instr_done = 1'b1;
            end
          endcase
        end
      end
      MIE_INDIRECT: begin
        next_state = MIE_IDLE;
        next_instr_done = 1'b1;
      end
      default: begin
        next_state = MIE_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= MIE_IDLE;
      ind_store <= 1'b0;
      ind_wsel <= '0;
      ind_off <= NIB_RST;
      instr_ready <= 1'b1;
      instr_done <= 1'b0;
    end else begin
      state <= next_state;
      ind_store <= next_ind_store;
      ind_wsel <= next_ind_wsel;
      ind_off <= next_ind_off;
      instr_ready <= next_instr_ready;
      instr_done <= next_instr_done;
    end
  end

  // Data memory; working registers are nibbles 0..15 of it
  always_comb begin
    next_mem = mem;
    case (state)
      MIE_IDLE: begin
        if (take && (op == MIE_OP_WR_LD)) begin
          next_mem[w_addr] = r_data;
        end
        if (mova) begin
          next_mem[r_addr] = mova_val;
        end
      end
      MIE_INDIRECT: begin
        // Page register is read here, so a page load just before takes effect
        if (ind_store) begin
          next_mem[paged_addr] = mem[ind_w_addr];
        end else begin
          next_mem[ind_w_addr] = mem[paged_addr];
        end
      end
      default: begin
        next_mem = mem;
      end
    endcase
  end

  // Working registers clear with the rest of memory
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < MEM_DEPTH; i++) begin
        mem[i] <= NIB_RST;
      end
    end else begin
      mem <= next_mem;
    end
  end

  // Timer preload, low nibble
  always_comb begin
    next_preload_low = timer_b_preload_low;
    if (take && (op == MIE_OP_PRELOAD_LO)) begin
      next_preload_low = r_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      timer_b_preload_low <= NIB_RST;
    end else begin
      timer_b_preload_low <= next_preload_low;
    end
  end

  // Timer preload, high nibble
  always_comb begin
    next_preload_high = timer_b_preload_high;
    if (take && (op == MIE_OP_PRELOAD_HI)) begin
      next_preload_high = r_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      timer_b_preload_high <= NIB_RST;
    end else begin
      timer_b_preload_high <= next_preload_high;
    end
  end

  // Page register
  always_comb begin
    next_page = memory_page_reg;
    if (take && (op == MIE_OP_PAGE_LD)) begin
      // All four bits load; only 2..0 steer the indirect moves
      next_page = r_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      memory_page_reg <= PAGE_RST;
    end else begin
      memory_page_reg <= next_page;
    end
  end

  // Accumulator and zero flag: only the flag-reading moves touch them
  always_comb begin
    next_acc_out = acc_out;
    if (mova) begin
      next_acc_out.accumulator = mova_val;
      next_acc_out.zero_flag = (mova_val == NIB_RST);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_out.accumulator <= NIB_RST;
      acc_out.zero_flag <= ZERO_RST;
    end else begin
      acc_out <= next_acc_out;
    end
  end

  // Peek shows memory as it stood before this edge's write
  always_comb begin
    next_peek_data = mem[peek_addr];
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      peek_data <= NIB_RST;
    end else begin
      peek_data <= next_peek_data;
    end
  end
endmodule

// ### sim/mie_core_assertions.sv
// Checker for the move-instruction execute block.
// Assumes it is bound to mie_core and sees only its ports.
module mie_core_checker
  import mie_pkg::*;
(
  // Clock, reset, instruction port
  input wire logic clk,
  input wire logic rst,
  input mie_pkg::mie_instr_s instr,
  input wire logic instr_ready,
  input wire logic instr_done,
  // Flags and results
  input wire logic carry_flag,
  input wire logic [7:0] hold_release_cause_flags,
  input mie_pkg::mie_acc_s acc_out,
  input wire logic [3:0] timer_b_preload_low,
  input wire logic [3:0] memory_page_reg
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [8:0] p9;
  logic [4:0] p5;
  logic tk, ind, mova, one;
  assign p9 = instr.word[15:7];
  assign p5 = instr.word[15:11];
  assign tk = instr.valid && instr_ready;
  assign ind = p5 == OP_WR_IND_LD || p5 == OP_WR_IND_ST;
  assign mova = p9 == OP_CARRY_MV || p9 == OP_HOLD_HI || p9 == OP_HOLD_LO;
  assign one = mova || p5 == OP_WR_LD || p9 == OP_PRELOAD_LO || p9 == OP_PRELOAD_HI
    || p9 == OP_PAGE_LD;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_ONE_CYCLE: assert property (tk && one |=> instr_done && instr_ready)
    else $error("one-cycle move not finished next cycle");
  AST_TWO_CYCLE: assert property (tk && ind |=> !instr_done && !instr_ready ##1 instr_done)
    else $error("indirect move not finished in two cycles");
  AST_NO_MATCH: assert property (tk && !one && !ind |=> !instr_done && $stable(acc_out))
    else $error("unknown word acted on");
  AST_CARRY: assert property (tk && p9 == OP_CARRY_MV |=>
    acc_out.accumulator == {3'h0, $past(carry_flag)})
    else $error("carry move wrong");
  AST_HOLD_HI: assert property (tk && p9 == OP_HOLD_HI |=>
    acc_out.accumulator == $past(hold_release_cause_flags[7:4]))
    else $error("upper cause nibble wrong");
  AST_HOLD_LO: assert property (tk && p9 == OP_HOLD_LO |=>
    acc_out.accumulator == ($past(hold_release_cause_flags[3:0]) & 4'h7))
    else $error("lower cause nibble wrong");
  AST_ZERO: assert property (tk && mova |=> acc_out.zero_flag == (acc_out.accumulator == 4'h0))
    else $error("zero flag wrong");
  AST_LOW_KEEP: assert property (!(tk && p9 == OP_PRELOAD_LO) |=> $stable(timer_b_preload_low))
    else $error("preload low changed");
endmodule
bind mie_core mie_core_checker u_chk(.clk, .rst, .instr, .instr_ready, .instr_done, .carry_flag,
  .hold_release_cause_flags, .acc_out, .timer_b_preload_low, .memory_page_reg);

// ### sim/mie_core_tb.sv
// Self-checking bench for the move-instruction execute block.
// Assumes mie_core and its checker are compiled; a model of memory predicts results.
module mie_core_tb import mie_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst, rdy, done, cf, pchk;
  mie_instr_s instr;
  mie_acc_s acc;
  logic [7:0] hf;
  logic [3:0] tl, th, pg, pk, ma, mtl, mth, mpg;
  logic [6:0] pa;
  logic mz;
  logic [3:0] m [128];
  logic [16:0] q [$];
  logic [8:0] p9t [6] = '{OP_PRELOAD_LO, OP_PRELOAD_HI, OP_PAGE_LD, OP_CARRY_MV, OP_HOLD_HI,
    OP_HOLD_LO};
  logic [4:0] p5t [4] = '{OP_WR_LD, OP_WR_IND_LD, OP_WR_IND_ST, 5'h00};
  int err_total, compares;
  mie_core u_dut(.clk, .rst, .instr, .instr_ready(rdy), .instr_done(done), .carry_flag(cf),
    .hold_release_cause_flags(hf), .acc_out(acc), .timer_b_preload_low(tl),
    .timer_b_preload_high(th), .memory_page_reg(pg), .peek_addr(pa), .peek_data(pk));
  always #2.5 clk = ~clk;
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task summarize;
    // A note left over means a result that never appeared
    if (q.size() != 0) err_total++;
    $display("Compares %0d, errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Predicts the result, offers the word and waits until it is taken
  task automatic ex(input logic [15:0] w);
    logic [3:0] v;
    logic [6:0] ia;
    logic hit;
    logic mv;
    v = m[w[6:0]];
    ia = {mpg[2:0], v};
    hit = 1;
    mv = 0;
    if (w[15:7] == OP_PRELOAD_LO) mtl = v;
    else if (w[15:7] == OP_PRELOAD_HI) mth = v;
    else if (w[15:7] == OP_PAGE_LD) mpg = v;
    else if (w[15:7] == OP_CARRY_MV) {mv, ma} = {1'b1, 3'h0, cf};
    else if (w[15:7] == OP_HOLD_HI) {mv, ma} = {1'b1, hf[7:4]};
    else if (w[15:7] == OP_HOLD_LO) {mv, ma} = {1'b1, hf[3:0] & 4'h7};
    else if (w[15:11] == OP_WR_LD) m[w[10:7]] = v;
    else if (w[15:11] == OP_WR_IND_LD) m[w[10:7]] = m[ia];
    else if (w[15:11] == OP_WR_IND_ST) m[ia] = m[w[10:7]];
    else hit = 0;
    if (mv) begin
      m[w[6:0]] = ma;
      mz = ma == 4'h0;
    end
    if (hit) q.push_back({ma, mz, mtl, mth, mpg});
    instr = '{1'b1, w};
    @(posedge clk);
    #1;
    if (w[15:11] == OP_WR_IND_LD || w[15:11] == OP_WR_IND_ST) begin
      instr.valid = 0;
      @(posedge clk);
      #1;
    end
  endtask
  // Memory is seen one cycle after the address settles
  task automatic peek(input logic [6:0] a);
    instr.valid = 0;
    pa = a;
    q.push_back({13'h0, m[a]});
    @(posedge clk);
    #1 pchk = 1;
    @(posedge clk);
    #1 pchk = 0;
  endtask
  always @(posedge clk) begin
    if (done === 1'b1 || pchk) begin
      // A result with no note behind it is an error of its own
      if (q.size() == 0) chk(17'h1ffff, 17'h00000);
      else chk(pchk ? {13'h0, pk} : {acc, tl, th, pg}, q.pop_front());
    end
  end
  initial begin
    logic [15:0] w;
    int k;
    clk = 0;
    rst = 1;
    instr = '0;
    cf = 0;
    hf = '0;
    pa = '0;
    pchk = 0;
    {ma, mz, mtl, mth, mpg} = '0;
    foreach (m[i]) m[i] = '0;
    void'($urandom(68469));
    repeat (5) @(posedge clk);
    #1 rst = 0;
    for (int i = 0; i < 600; i++) begin
      w = $urandom;
      k = $urandom % 10;
      cf = $urandom;
      hf = $urandom;
      if (k < 6) w[15:7] = p9t[k];
      else w[15:11] = p5t[k-6];
      if (k == 9) w[10:7] = 4'h0;
      ex(w);
      if (i % 5 == 4) peek($urandom);
    end
    peek(7'h00);
    summarize();
  end
  initial begin
    #100us;
    err_total++;
    summarize();
  end
endmodule
